// file: cmc_pkg.sv
// shared constants and types for the comparator mode control block
`default_nettype none

package cmc_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_IDX = 8'h1F; // comparator_control
	localparam logic [7:0] DIR_IDX = 8'h85; // port_a_direction
	localparam logic [7:0] STAT_IDX = 8'h90; // interrupt status
	localparam logic [7:0] MASK_IDX = 8'h91; // interrupt mask
	localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [11:0] DIR_ADDR = {2'h0, DIR_IDX, 2'h0};
	localparam logic [11:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
	localparam logic [11:0] MASK_ADDR = {2'h0, MASK_IDX, 2'h0};

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_SECOND_BIT = 7;
	localparam int CTRL_FIRST_BIT = 6;
	localparam int CTRL_CIS_BIT = 3;
	localparam int STAT_FLAG_BIT = 0; // compare_change_flag, write one clears
	localparam int STAT_SETTLED_BIT = 1; // read only, outputs settled
	localparam int STAT_SIM_BIT = 8; // write one sets the flag
	localparam int MASK_EN_BIT = 0; // compare_change_enable
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [4:0] DIR_RESET = 5'h1F;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int MODE_DELAY_NS = 10000; // mode change settling time
	localparam int SETTLE_CYC = (MODE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// modes and analog input sources
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CMC_MODE_RESET, CMC_MODE_MUX_SHARED, CMC_MODE_VREF, CMC_MODE_COMMON_REF,
		CMC_MODE_INDEP, CMC_MODE_ONE, CMC_MODE_PIN_OUT, CMC_MODE_OFF
	} cmc_mode_e;

	typedef enum logic [2:0] {
		CMC_SRC_OFF, CMC_SRC_PIN0, CMC_SRC_PIN1, CMC_SRC_PIN2, CMC_SRC_PIN3, CMC_SRC_VREF
	} cmc_src_e;

endpackage

`default_nettype wire

// file: cmc_comparator_ctrl.sv
// comparator mode control: apb registers, pin muxing, change interrupt
//
// The APB slave port is this design's own decision.
`default_nettype none

module cmc_comparator_ctrl (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic first_cmp_raw,
	input wire logic second_cmp_raw,
	input wire logic [4:3] port_latch,
	output logic [4:3] pin_out,
	output logic [4:0] pin_oe,
	output logic [3:0] pin_analog,
	output logic first_cmp_enable,
	output logic second_cmp_enable,
	output cmc_pkg::cmc_src_e first_minus_src,
	output cmc_pkg::cmc_src_e first_plus_src,
	output cmc_pkg::cmc_src_e second_minus_src,
	output cmc_pkg::cmc_src_e second_plus_src,
	output logic irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [2:0] comparator_mode_field;
	logic input_switch_select;
	logic [4:0] port_a_direction;
	logic compare_change_flag;
	logic compare_change_enable;
	logic [1:0] last_seen;
	logic [1:0] cmp_state;
	logic [8:0] settle_cnt;
	logic [2:0] sync_first;
	logic [2:0] sync_second;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire hit_ctrl = paddr == cmc_pkg::CTRL_ADDR;
	wire hit_dir = paddr == cmc_pkg::DIR_ADDR;
	wire hit_stat = paddr == cmc_pkg::STAT_ADDR;
	wire hit_mask = paddr == cmc_pkg::MASK_ADDR;
	wire hit_any = hit_ctrl | hit_dir | hit_stat | hit_mask;
	wire wr = access & pwrite;
	wire wr_ctrl = wr & hit_ctrl;
	wire wr_dir = wr & hit_dir;
	wire wr_stat = wr & hit_stat;
	wire wr_mask = wr & hit_mask;
	wire ctrl_touch = access & hit_ctrl;

	// zero wait states, error only for unmapped words
	assign pready = 1'b1;
	assign pslverr = access & ~hit_any;

	// ----------------------------------------------------------------
	// comparator result synchronisers
	// ----------------------------------------------------------------
	wire [1:0] raw_in = {second_cmp_raw, first_cmp_raw};
	wire [1:0] s2 = {sync_second[1], sync_first[1]};
	wire [1:0] s3 = {sync_second[2], sync_first[2]};

	// three flops, a change counts once stages two and three agree
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_first <= 3'h0;
			sync_second <= 3'h0;
		end else begin
			sync_first <= {sync_first[1:0], raw_in[0]};
			sync_second <= {sync_second[1:0], raw_in[1]};
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cmp
			// accepted result per comparator
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					cmp_state[gi] <= 1'b0;
				end else if (s2[gi] == s3[gi]) begin
					cmp_state[gi] <= s3[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// mode decode and multiplexers
	// ----------------------------------------------------------------
	wire [1:0] result = cmp_state & {second_cmp_enable, first_cmp_enable};
	wire second_compare_result = result[1];
	wire first_compare_result = result[0];
	cmc_pkg::cmc_mode_e mode;
	assign mode = cmc_pkg::cmc_mode_e'(comparator_mode_field);
	wire pins_out_mode = mode == cmc_pkg::CMC_MODE_PIN_OUT;

	// input routing per mode
	always_comb begin
		first_cmp_enable = 1'b1;
		second_cmp_enable = 1'b1;
		pin_analog = 4'hF;
		first_minus_src = cmc_pkg::CMC_SRC_PIN0;
		first_plus_src = cmc_pkg::CMC_SRC_PIN3;
		second_minus_src = cmc_pkg::CMC_SRC_PIN1;
		second_plus_src = cmc_pkg::CMC_SRC_PIN2;
		case (mode)
			cmc_pkg::CMC_MODE_RESET, cmc_pkg::CMC_MODE_OFF: begin
				first_cmp_enable = 1'b0;
				second_cmp_enable = 1'b0;
				pin_analog = (mode == cmc_pkg::CMC_MODE_OFF) ? 4'h0 : 4'hF;
				first_minus_src = cmc_pkg::CMC_SRC_OFF;
				first_plus_src = cmc_pkg::CMC_SRC_OFF;
				second_minus_src = cmc_pkg::CMC_SRC_OFF;
				second_plus_src = cmc_pkg::CMC_SRC_OFF;
			end
			cmc_pkg::CMC_MODE_MUX_SHARED: begin
				first_minus_src = input_switch_select ? cmc_pkg::CMC_SRC_PIN3
					: cmc_pkg::CMC_SRC_PIN0;
				first_plus_src = cmc_pkg::CMC_SRC_PIN2;
			end
			cmc_pkg::CMC_MODE_VREF: begin
				first_minus_src = input_switch_select ? cmc_pkg::CMC_SRC_PIN3
					: cmc_pkg::CMC_SRC_PIN0;
				second_minus_src = input_switch_select ? cmc_pkg::CMC_SRC_PIN2
					: cmc_pkg::CMC_SRC_PIN1;
				first_plus_src = cmc_pkg::CMC_SRC_VREF;
				second_plus_src = cmc_pkg::CMC_SRC_VREF;
			end
			cmc_pkg::CMC_MODE_COMMON_REF, cmc_pkg::CMC_MODE_PIN_OUT: begin
				pin_analog = 4'h7;
				first_plus_src = cmc_pkg::CMC_SRC_PIN2;
			end
			cmc_pkg::CMC_MODE_ONE: begin
				first_cmp_enable = 1'b0;
				pin_analog = 4'h6;
				first_minus_src = cmc_pkg::CMC_SRC_OFF;
				first_plus_src = cmc_pkg::CMC_SRC_OFF;
			end
			default: begin
				pin_analog = 4'hF;
			end
		endcase
	end

	// output multiplexers, raw results in mode 110
	assign pin_out[3] = pins_out_mode ? first_cmp_raw : port_latch[3];
	assign pin_out[4] = pins_out_mode ? second_cmp_raw : port_latch[4];
	// direction bit clear means the pin drives
	assign pin_oe = ~port_a_direction;

	// ----------------------------------------------------------------
	// control and direction registers
	// ----------------------------------------------------------------
	// only the low nibble stores, bits 5:4 drop writes
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			{input_switch_select, comparator_mode_field} <= cmc_pkg::CTRL_RESET;
			port_a_direction <= cmc_pkg::DIR_RESET;
		end else begin
			if (wr_ctrl) begin
				{input_switch_select, comparator_mode_field} <= pwdata[3:0];
			end
			if (wr_dir) begin
				port_a_direction <= pwdata[4:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// settle timer after a mode change
	// ----------------------------------------------------------------
	wire mode_change = wr_ctrl & (pwdata[2:0] != comparator_mode_field);
	wire settled = settle_cnt == 9'h000;

	// reload on each new mode, count down to settled
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			settle_cnt <= 9'h000;
		end else if (mode_change) begin
			settle_cnt <= 9'(cmc_pkg::SETTLE_CYC);
		end else if (!settled) begin
			settle_cnt <= settle_cnt - 9'h001;
		end
	end

	// ----------------------------------------------------------------
	// change flag, mask and interrupt
	// ----------------------------------------------------------------
	wire mismatch = result != last_seen;
	wire flag_set = mismatch | (wr_stat & pwdata[cmc_pkg::STAT_SIM_BIT]);
	wire flag_clr = wr_stat & pwdata[cmc_pkg::STAT_FLAG_BIT];
	wire next_flag = flag_set | (compare_change_flag & ~flag_clr);

	// any control access relatches results; set beats clear
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			last_seen <= 2'h0;
			compare_change_flag <= 1'b0;
			compare_change_enable <= 1'b0;
		end else begin
			if (ctrl_touch) begin
				last_seen <= result;
			end
			compare_change_flag <= next_flag;
			if (wr_mask) begin
				compare_change_enable <= pwdata[cmc_pkg::MASK_EN_BIT];
			end
		end
	end

	// mask gates the level output, not the flag
	assign irq = compare_change_flag & compare_change_enable;

	// ----------------------------------------------------------------
	// read data, captured in the setup cycle
	// ----------------------------------------------------------------
	wire [31:0] rd_ctrl = {24'h0, second_compare_result, first_compare_result, 2'b00,
		input_switch_select, comparator_mode_field};
	wire [31:0] rd_dir = {27'h0, port_a_direction};
	wire [31:0] rd_stat = {30'h0, settled, compare_change_flag};
	wire [31:0] rd_mask = {31'h0, compare_change_enable};
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl
		: hit_dir ? rd_dir
		: hit_stat ? rd_stat
		: hit_mask ? rd_mask
		: 32'h0;

	// read word frozen for the access phase
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h0;
		end else if (setup) begin
			prdata <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	localparam int SETTLE_BOUND = 501;

	sequence s_ctrl_write;
		wr_ctrl;
	endsequence

	sequence s_mode_moved;
		wr_ctrl ##1 $changed(comparator_mode_field);
	endsequence

	a_ctrl_bit7_second: assert property (@(posedge ref_clk) disable iff (sys_rst)
		setup & hit_ctrl & ~pwrite |=> prdata[7] == $past(second_compare_result))
		else $error("control bit 7 not second result");

	a_ctrl_bit6_first: assert property (@(posedge ref_clk) disable iff (sys_rst)
		setup & hit_ctrl & ~pwrite |=> prdata[6] == $past(first_compare_result))
		else $error("control bit 6 not first result");

	a_ctrl_gap_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
		setup & hit_ctrl |=> prdata[5:4] == 2'b00)
		else $error("unimplemented control bits not zero");

	a_ctrl_write_back: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_ctrl_write |=> {input_switch_select, comparator_mode_field} == $past(pwdata[3:0]))
		else $error("control low nibble not stored");

	a_reset_mode_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mode == cmc_pkg::CMC_MODE_RESET |-> !first_cmp_enable && !second_cmp_enable
		&& pin_analog == 4'hF)
		else $error("reset mode not all analog and off");

	a_vref_plus: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mode == cmc_pkg::CMC_MODE_VREF |-> first_plus_src == cmc_pkg::CMC_SRC_VREF
		&& second_plus_src == cmc_pkg::CMC_SRC_VREF)
		else $error("reference not routed in mode 010");

	a_switch_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mode == cmc_pkg::CMC_MODE_COMMON_REF |-> first_minus_src == cmc_pkg::CMC_SRC_PIN0)
		else $error("input switch acted in a mode without it");

	a_pin_raw_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pins_out_mode |-> pin_out[4] == second_cmp_raw && pin_out[3] == first_cmp_raw)
		else $error("mode 110 pins do not carry raw results");

	a_dir_gates_oe: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(port_a_direction[3]) |-> !pin_oe[3])
		else $error("direction bit does not gate driver");

	// a newer mode change restarts the window, so it also ends this attempt
	a_settle_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_mode_moved |-> !settled [*8] ##[1:SETTLE_BOUND] (settled || mode_change))
		else $error("settle window wrong after mode change");

	a_settle_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mode_change |=> settle_cnt == 9'(cmc_pkg::SETTLE_CYC))
		else $error("settle timer not reloaded on mode change");

	a_flag_on_change: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mismatch |=> compare_change_flag)
		else $error("mismatch did not set flag");

	a_flag_sim_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_stat & pwdata[cmc_pkg::STAT_SIM_BIT] ##1 !wr_stat [*2] |-> compare_change_flag)
		else $error("simulated flag not held");

	a_irq_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_mask ##1 compare_change_flag |-> irq == $past(pwdata[cmc_pkg::MASK_EN_BIT]))
		else $error("interrupt line not gated by mask");

	a_flag_write_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_stat & pwdata[cmc_pkg::STAT_FLAG_BIT] & ~pwdata[cmc_pkg::STAT_SIM_BIT]
		& ~mismatch |=> !compare_change_flag)
		else $error("write one did not clear flag");

	a_touch_relatch: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ctrl_touch |=> last_seen == $past(result))
		else $error("control access did not relatch results");

endmodule

`default_nettype wire

// file: cmc_comparator_ctrl_tb_top.sv
// self-checking testbench for the comparator mode control block
`default_nettype none

module cmc_comparator_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [11:0] CA = cmc_pkg::CTRL_ADDR;
	localparam logic [11:0] DA = cmc_pkg::DIR_ADDR;
	localparam logic [11:0] SA = cmc_pkg::STAT_ADDR;
	localparam logic [11:0] MA = cmc_pkg::MASK_ADDR;

	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic first_cmp_raw = 1'b0;
	logic second_cmp_raw = 1'b0;
	logic [4:3] port_latch = 2'h2;
	logic [4:3] pin_out;
	logic [4:0] pin_oe;
	logic [3:0] pin_analog;
	logic first_cmp_enable;
	logic second_cmp_enable;
	cmc_pkg::cmc_src_e first_minus_src, first_plus_src, second_minus_src, second_plus_src;
	logic irq;
	int fail_count = 0;
	int checked = 0;
	logic [31:0] rd;
	logic err;
	logic [3:0] ana [8] = '{4'hF, 4'hF, 4'hF, 4'h7, 4'hF, 4'h6, 4'h7, 4'h0};

	cmc_comparator_ctrl dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .first_cmp_raw(first_cmp_raw),
		.second_cmp_raw(second_cmp_raw), .port_latch(port_latch), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_analog(pin_analog), .first_cmp_enable(first_cmp_enable),
		.second_cmp_enable(second_cmp_enable), .first_minus_src(first_minus_src),
		.first_plus_src(first_plus_src), .second_minus_src(second_minus_src),
		.second_plus_src(second_plus_src), .irq(irq)
	);

	// ----------------------------------------------------------------
	// clock and helpers
	// ----------------------------------------------------------------
	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;

	task automatic end_of_test();
		$display("checked %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk,
		input string what);
		checked++;
		if ((got & msk) !== (exp & msk)) begin
			fail_count++;
			$display("MISMATCH at %0t: %s got %h want %h", $time, what, got & msk, exp & msk);
		end
	endtask

	// one apb transfer, held until pready at a rising edge
	task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			$display("MISMATCH at %0t: no pready", $time);
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk,
		input string what);
		apb(1'b0, a, 32'h0);
		check(rd, exp, msk, what);
	endtask

	// lets the edge updates land before outputs are looked at
	task automatic settle();
		@(negedge ref_clk);
	endtask

	// expected {first minus, first plus, second minus, second plus}
	function automatic logic [31:0] exp_src(input int m);
		logic [2:0] a;
		logic c;
		c = m[3];
		a = c ? 3'h4 : 3'h1;
		case (m % 8)
			1: return {20'h0, a, 3'h3, 3'h2, 3'h3};
			2: return {20'h0, a, 3'h5, c ? 3'h3 : 3'h2, 3'h5};
			3, 6: return {20'h0, 3'h1, 3'h3, 3'h2, 3'h3};
			4: return {20'h0, 3'h1, 3'h4, 3'h2, 3'h3};
			5: return {20'h0, 3'h0, 3'h0, 3'h2, 3'h3};
			default: return 32'h0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		settle();
		check({27'h0, pin_oe}, 32'h0, 32'h1F, "reset oe");
		check({28'h0, pin_analog}, 32'hF, 32'hF, "reset analog");
		check({31'h0, irq}, 32'h0, 32'h1, "reset irq");
		rdc(CA, 32'h0, 32'hFF, "ctrl reset");
		rdc(DA, 32'h1F, 32'hFFFFFFFF, "dir reset");
		rdc(MA, 32'h0, 32'h1, "mask reset");
		$display("test reset done");

		// field access, refused address
		wr(CA, 32'hFFFFFFFF);
		rdc(CA, 32'h0F, 32'hFF, "ctrl bits");
		wr(DA, 32'hFFFFFF07);
		rdc(DA, 32'h07, 32'hFFFFFFFF, "dir bits");
		settle();
		check({27'h0, pin_oe}, 32'h18, 32'h1F, "oe from dir");
		wr(12'h100, 32'h5);
		check({31'h0, err}, 32'h1, 32'h1, "slverr write");
		rdc(12'h100, 32'h0, 32'hFFFFFFFF, "unmapped read");
		check({31'h0, err}, 32'h1, 32'h1, "slverr read");
		$display("test access done");

		// every mode with both switch settings
		for (int m = 0; m < 16; m++) begin
			wr(CA, m);
			settle();
			check({20'h0, first_minus_src, first_plus_src, second_minus_src, second_plus_src},
				exp_src(m), 32'hFFF, "sources");
			check({30'h0, first_cmp_enable, second_cmp_enable},
				(m % 8 == 0 || m % 8 == 7) ? 0 : (m % 8 == 5 ? 1 : 3), 3, "enables");
			check({28'h0, pin_analog}, ana[m % 8], 32'hF, "analog");
		end
		$display("test modes done");

		// raw results on pins in mode 110
		wr(CA, 32'h6);
		@(posedge ref_clk);
		first_cmp_raw <= 1'b1;
		settle();
		check({30'h0, pin_out}, 32'h1, 32'h3, "pin out first");
		@(posedge ref_clk);
		first_cmp_raw <= 1'b0;
		second_cmp_raw <= 1'b1;
		settle();
		check({30'h0, pin_out}, 32'h2, 32'h3, "pin out second");
		check({27'h0, pin_oe}, 32'h18, 32'h1F, "oe in 110");
		wr(CA, 32'h4);
		port_latch <= 2'h1;
		settle();
		check({30'h0, pin_out}, 32'h1, 32'h3, "pin out latch");
		wr(DA, 32'h1F);
		settle();
		check({27'h0, pin_oe}, 32'h0, 32'h1F, "oe released");
		$display("test pins done");

		// result bits
		repeat (8) @(posedge ref_clk);
		rdc(CA, 32'h84, 32'hFF, "second result");
		first_cmp_raw <= 1'b1;
		second_cmp_raw <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rdc(CA, 32'h44, 32'hFF, "first result");
		$display("test results done");

		// change flag, mask, simulated event
		wr(SA, 32'h1);
		rdc(SA, 32'h0, 32'h1, "flag cleared");
		first_cmp_raw <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rdc(SA, 32'h1, 32'h1, "flag on change");
		settle();
		check({31'h0, irq}, 32'h0, 32'h1, "irq masked");
		wr(MA, 32'h1);
		settle();
		check({31'h0, irq}, 32'h1, 32'h1, "irq enabled");
		wr(SA, 32'h1);
		rdc(SA, 32'h1, 32'h1, "mismatch persists");
		rdc(CA, 32'h04, 32'hFF, "relatch");
		wr(SA, 32'h1);
		rdc(SA, 32'h0, 32'h1, "flag after relatch");
		settle();
		check({31'h0, irq}, 32'h0, 32'h1, "irq low");
		wr(SA, 32'h100);
		rdc(CA, 32'h04, 32'hFF, "ctrl access");
		rdc(SA, 32'h1, 32'h1, "simulated flag stays");
		settle();
		check({31'h0, irq}, 32'h1, 32'h1, "irq simulated");
		wr(MA, 32'h0);
		settle();
		check({31'h0, irq}, 32'h0, 32'h1, "irq remasked");
		wr(SA, 32'h1);
		$display("test interrupt done");

		// settling window after a mode change
		wr(CA, 32'h3);
		rdc(SA, 32'h0, 32'h2, "unsettled");
		repeat (cmc_pkg::SETTLE_CYC - 12) @(posedge ref_clk);
		rdc(SA, 32'h0, 32'h2, "still unsettled");
		repeat (12) @(posedge ref_clk);
		rdc(SA, 32'h2, 32'h2, "settled");
		$display("test settle done");
		end_of_test();
	end
endmodule

`default_nettype wire
